// [sdi_pkg.sv]
package sdi_pkg;
  localparam int          SDI_CLK_PERIOD_NS = 20;
  localparam int          SDI_FILT_SHORT_NS = 50;
  localparam int          SDI_FILT_LONG_NS  = 3000;
  localparam int          SDI_FILT_SHORT_I  = (SDI_FILT_SHORT_NS / SDI_CLK_PERIOD_NS < 1) ? 1 :
                                              SDI_FILT_SHORT_NS / SDI_CLK_PERIOD_NS;
  localparam int          SDI_FILT_LONG_I   = SDI_FILT_LONG_NS / SDI_CLK_PERIOD_NS + 1;
  localparam logic [7:0]  SDI_FILT_SHORT_CYC = 8'(SDI_FILT_SHORT_I);
  localparam logic [7:0]  SDI_FILT_LONG_CYC  = 8'(SDI_FILT_LONG_I);
  localparam logic [7:0]  SDI_ADDR_CMD    = 8'h00;
  localparam logic [7:0]  SDI_ADDR_MODE   = 8'h04;
  localparam logic [7:0]  SDI_ADDR_ENV1   = 8'h08;
  localparam logic [7:0]  SDI_ADDR_MAIN_STATUS   = 8'h0C;
  localparam logic [7:0]  SDI_ADDR_XSTS   = 8'h10;
  localparam logic [7:0]  SDI_ADDR_SUB_STATUS   = 8'h14;
  localparam logic [7:0]  SDI_ADDR_CAUSE  = 8'h18;
  localparam logic [1:0]  SDI_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  SDI_RESP_SLVERR = 2'h2;
  localparam logic [7:0]  SDI_CMD_EMG     = 8'h05;
  localparam logic [7:0]  SDI_CMD_CLR_OUT = 8'h24;
  localparam logic [7:0]  SDI_CMD_CLR_RST = 8'h25;
  localparam logic [7:0]  SDI_CMD_START   = 8'h50;
  localparam int          SDI_B_ALM_STYLE = 8;
  localparam int          SDI_B_ALM_POL   = 9;
  localparam int          SDI_B_CLR_FAULT = 10;
  localparam int          SDI_B_CLR_HOME  = 11;
  localparam int          SDI_B_EPW_LO    = 12;
  localparam int          SDI_B_CLR_POL   = 15;
  localparam int          SDI_B_ETW_LO    = 16;
  localparam int          SDI_B_INP_POL   = 22;
  localparam int          SDI_B_FILT      = 26;
  localparam int          SDI_B_INP_WAIT  = 9;
  localparam logic [31:0] SDI_ENV1_MASK   = 32'h0443_FF00;
  localparam logic [31:0] SDI_MODE_MASK   = 32'h0000_027F;
  localparam logic [31:0] SDI_ENV1_RST    = 32'h0000_0000;
  localparam logic [31:0] SDI_MODE_RST    = 32'h0000_0000;
  localparam int          SDI_B_XS_CLR    = 9;
  localparam int          SDI_B_XS_INP    = 16;
  localparam int          SDI_B_SS_ALM    = 11;
  localparam int          SDI_B_CAUSE_ALM = 7;
  localparam int          SDI_B_MS_RUN    = 0;
  localparam int          SDI_B_MS_END    = 1;
  localparam int          SDI_B_MS_ERR    = 2;
  localparam int          SDI_B_MS_CODE   = 4;
  localparam logic [2:0]  SDI_EPW_LEVEL   = 3'h7;
  localparam logic [3:0]  SDI_CODE_IDLE   = 4'h0;
  localparam logic [3:0]  SDI_CODE_RUN    = 4'h1;
  localparam logic [3:0]  SDI_CODE_CLRW   = 4'h5;
  localparam logic [3:0]  SDI_CODE_INPW   = 4'hE;
  localparam logic [3:0]  SDI_STOP_NORMAL = 4'h0;
  localparam logic [3:0]  SDI_STOP_ALARM  = 4'h1;
  localparam logic [3:0]  SDI_STOP_EMG    = 4'h2;
  localparam logic [3:0]  SDI_STOP_LIMIT  = 4'h3;
  localparam logic [11:0] SDI_EPW_CYC [0:6] = '{12'h032, 12'h064, 12'h0C8, 12'h190, 12'h320, 12'h640, 12'hC80};
  localparam logic [11:0] SDI_ETW_CYC [0:3] = '{12'h000, 12'h032, 12'h190, 12'hC80};
  typedef enum logic [4:0] {
    SDI_ST_IDLE  = 5'b00001,
    SDI_ST_RUN   = 5'b00010,
    SDI_ST_DECEL = 5'b00100,
    SDI_ST_CLRW  = 5'b01000,
    SDI_ST_INPW  = 5'b10000
  } sdi_state_t;
endpackage

// [sdi_servo_if.sv]
`timescale 1ns/1ps
// Overview of operation
// - wait for in-position before completing, code 1110b
// - main status updates held until in-position
// - error, emergency, alarm stops complete without waiting
// - in-position already on: complete at once
// - in-position polarity bit 22
// - shared filter bit 26: 50ns pass, 3us reject
// - in-position state readable, extended status 16
// - clear width field 14:12, 111b level mode
// - delay after clear off, field 17:16
// - auto clear pulse on origin return completion
// - auto clear on immediate abnormal stop only
// - limits, alarm, emergency input/command trigger clear
// - command 24h drives clear output anytime
// - clear polarity bit 15, state status 9
// - command 25h resets clear, ends wait 0101b
// - command 05h stops, completes, drops queued operation
// - alarm while not idle causes abnormal stop
// - alarm style bit 8: immediate or decelerate
// - start refused while alarm on
// - alarm polarity bit 9
// - alarm stop sets cause bit 7, status 11
module sdi_servo_if
  import sdi_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        in_position_input,
  input  wire logic        driver_alarm_input,
  input  wire logic        emergency_stop_input,
  input  wire logic        end_limit_input_pos,
  input  wire logic        end_limit_input_neg,
  input  wire logic        pulse_done,
  input  wire logic        homing_done,
  input  wire logic        high_speed_pattern,
  output logic             deviation_clear_output,
  output logic             pulse_enable,
  output logic             decel_request,
  output logic             operation_complete
);
  localparam int NCH = 5;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic              awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic              aw_full_r, w_full_r;
  logic [7:0]        waddr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic [1:0]        bresp_r, rresp_r;
  logic [31:0]       rdata_r;
  logic              wr_en;
  logic [31:0]       env1_r, mode_r;
  logic              cause_alm_r;
  logic [NCH-1:0]    pin_raw, sync1_r, sync2_r, filt_w;
  logic              inp_on, alm_on, emg_on, lim_on;
  logic              cmd_v;
  logic              cmd_emg, cmd_clr_out, cmd_clr_rst, cmd_start;
  sdi_state_t        state_r, state_nxt;
  logic              queued_r;
  logic              done_nxt, err_nxt, fault_trig, home_trig, alarm_stop;
  logic [3:0]        stop_nxt;
  logic              erc_on_r, erc_dly_r;
  logic [11:0]       erc_cnt_r;
  logic              erc_busy, erc_trig;
  logic [2:0]        clear_on_width;
  logic [1:0]        clear_off_delay;
  logic              ms_run_r, ms_end_r, ms_err_r;
  logic [3:0]        ms_code_r;
  logic              erc_pin_r, pulse_en_r, decel_r, complete_r;
  logic [3:0]        state_code;
  logic [31:0]       rd_val;
  logic              rd_ok;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res & msk;
  endfunction

  // bus slave: address and data are taken independently, write runs once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      aw_full_r <= 1'b0;
      waddr_r   <= 8'h00;
    end else begin
      awready_r <= awvalid & ~awready_r & ~aw_full_r & ~bvalid_r;
      if (awvalid & awready_r) begin
        aw_full_r <= 1'b1;
        waddr_r   <= awaddr;
      end else if (wr_en) begin
        aw_full_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready_r <= 1'b0;
      w_full_r <= 1'b0;
      wdata_r  <= 32'h0000_0000;
      wstrb_r  <= 4'h0;
    end else begin
      wready_r <= wvalid & ~wready_r & ~w_full_r & ~bvalid_r;
      if (wvalid & wready_r) begin
        w_full_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end else if (wr_en) begin
        w_full_r <= 1'b0;
      end
    end
  end

  assign wr_en = aw_full_r & w_full_r & ~bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r  <= SDI_RESP_OKAY;
    end else if (wr_en) begin
      bvalid_r <= 1'b1;
      bresp_r  <= (waddr_r == SDI_ADDR_CMD || waddr_r == SDI_ADDR_MODE || waddr_r == SDI_ADDR_ENV1 ||
                   waddr_r == SDI_ADDR_CAUSE || waddr_r == SDI_ADDR_MAIN_STATUS || waddr_r == SDI_ADDR_XSTS ||
                   waddr_r == SDI_ADDR_SUB_STATUS) ? SDI_RESP_OKAY : SDI_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      env1_r <= SDI_ENV1_RST;
      mode_r <= SDI_MODE_RST;
    end else if (wr_en) begin
      if (waddr_r == SDI_ADDR_ENV1) begin
        env1_r <= apply_strb(env1_r, wdata_r, wstrb_r, SDI_ENV1_MASK);
      end
      if (waddr_r == SDI_ADDR_MODE) begin
        mode_r <= apply_strb(mode_r, wdata_r, wstrb_r, SDI_MODE_MASK);
      end
    end
  end

  assign cmd_v       = wr_en & (waddr_r == SDI_ADDR_CMD) & wstrb_r[0];
  assign cmd_emg     = cmd_v & (wdata_r[7:0] == SDI_CMD_EMG);
  assign cmd_clr_out = cmd_v & (wdata_r[7:0] == SDI_CMD_CLR_OUT);
  assign cmd_clr_rst = cmd_v & (wdata_r[7:0] == SDI_CMD_CLR_RST);
  assign cmd_start   = cmd_v & (wdata_r[7:0] == SDI_CMD_START);

  assign state_code = (state_r == SDI_ST_IDLE) ? SDI_CODE_IDLE :
                      (state_r == SDI_ST_CLRW) ? SDI_CODE_CLRW :
                      (state_r == SDI_ST_INPW) ? SDI_CODE_INPW : SDI_CODE_RUN;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (araddr)
      SDI_ADDR_CMD:   rd_val = 32'h0000_0000;
      SDI_ADDR_MODE:  rd_val = mode_r;
      SDI_ADDR_ENV1:  rd_val = env1_r;
      SDI_ADDR_MAIN_STATUS: begin
        rd_val[SDI_B_MS_RUN]         = ms_run_r;
        rd_val[SDI_B_MS_END]         = ms_end_r;
        rd_val[SDI_B_MS_ERR]         = ms_err_r;
        rd_val[SDI_B_MS_CODE +: 4]   = ms_code_r;
      end
      SDI_ADDR_XSTS: begin
        rd_val[3:0]          = state_code;
        rd_val[SDI_B_XS_CLR] = erc_on_r;
        rd_val[SDI_B_XS_INP] = inp_on;
      end
      SDI_ADDR_SUB_STATUS:  rd_val[SDI_B_SS_ALM] = alm_on;
      SDI_ADDR_CAUSE: rd_val[SDI_B_CAUSE_ALM] = cause_alm_r;
      default:        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= SDI_RESP_OKAY;
    end else begin
      arready_r <= arvalid & ~arready_r & ~rvalid_r;
      if (arvalid & arready_r) begin
        rvalid_r <= 1'b1;
        rdata_r  <= rd_val;
        rresp_r  <= rd_ok ? SDI_RESP_OKAY : SDI_RESP_SLVERR;
      end else if (rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // input conditioning, one filter per pin
  assign pin_raw = {end_limit_input_neg, end_limit_input_pos, emergency_stop_input,
                    driver_alarm_input, in_position_input};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= '1;
      sync2_r <= '1;
    end else begin
      sync1_r <= pin_raw;
      sync2_r <= sync1_r;
    end
  end

  for (genvar g = 0; g < NCH; g++) begin : g_filt
    logic [7:0] cnt_r;
    logic       bit_r;
    logic [7:0] thr;
    // filtered level changes only after the new level held thr cycles in a row
    assign thr = env1_r[SDI_B_FILT] ? SDI_FILT_LONG_CYC : SDI_FILT_SHORT_CYC;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_r <= 8'h00;
        bit_r <= 1'b1;
      end else if (sync2_r[g] == bit_r) begin
        cnt_r <= 8'h00;
      end else if (cnt_r + 8'h01 == thr) begin
        cnt_r <= 8'h00;
        bit_r <= sync2_r[g];
      end else begin
        cnt_r <= cnt_r + 8'h01;
      end
    end
    assign filt_w[g] = bit_r;
  end

  assign inp_on = ~(filt_w[0] ^ env1_r[SDI_B_INP_POL]);
  assign alm_on = ~(filt_w[1] ^ env1_r[SDI_B_ALM_POL]);
  assign emg_on = ~filt_w[2];
  assign lim_on = ~filt_w[3] | ~filt_w[4];

  // axis sequencing; stops are judged in priority emergency, limit, alarm
  always_comb begin
    state_nxt  = state_r;
    done_nxt   = 1'b0;
    err_nxt    = 1'b0;
    stop_nxt   = SDI_STOP_NORMAL;
    fault_trig = 1'b0;
    home_trig  = 1'b0;
    alarm_stop = 1'b0;
    unique case (state_r)
      SDI_ST_IDLE: begin
        if (cmd_start && !alm_on) begin
          state_nxt = SDI_ST_RUN;
        end
      end
      default: begin
        if (cmd_emg || emg_on) begin
          state_nxt  = SDI_ST_IDLE;
          done_nxt   = 1'b1;
          err_nxt    = 1'b1;
          stop_nxt   = SDI_STOP_EMG;
          fault_trig = 1'b1;
        end else if (lim_on && (state_r == SDI_ST_RUN || state_r == SDI_ST_DECEL)) begin
          // immediate limit stop counts only while running or decelerating, not in clear or in-position wait
          state_nxt  = SDI_ST_IDLE;
          done_nxt   = 1'b1;
          err_nxt    = 1'b1;
          stop_nxt   = SDI_STOP_LIMIT;
          fault_trig = 1'b1;
        end else if (alm_on && state_r != SDI_ST_DECEL) begin
          if (env1_r[SDI_B_ALM_STYLE] && high_speed_pattern && state_r == SDI_ST_RUN) begin
            state_nxt = SDI_ST_DECEL;
          end else begin
            state_nxt  = SDI_ST_IDLE;
            done_nxt   = 1'b1;
            err_nxt    = 1'b1;
            stop_nxt   = SDI_STOP_ALARM;
            fault_trig = 1'b1;
            alarm_stop = 1'b1;
          end
        end else if (state_r == SDI_ST_DECEL) begin
          if (pulse_done) begin
            state_nxt  = SDI_ST_IDLE;
            done_nxt   = 1'b1;
            err_nxt    = 1'b1;
            stop_nxt   = SDI_STOP_ALARM;
            alarm_stop = 1'b1;
          end
        end else if (state_r == SDI_ST_INPW) begin
          if (inp_on) begin
            state_nxt = SDI_ST_IDLE;
            done_nxt  = 1'b1;
          end
        end else if ((state_r == SDI_ST_RUN && (pulse_done || homing_done)) ||
                     (state_r == SDI_ST_CLRW && !erc_busy)) begin
          if (state_r == SDI_ST_RUN && homing_done && env1_r[SDI_B_CLR_HOME]) begin
            state_nxt = SDI_ST_CLRW;
            home_trig = 1'b1;
          end else if (mode_r[SDI_B_INP_WAIT] && !inp_on) begin
            state_nxt = SDI_ST_INPW;
          end else begin
            state_nxt = SDI_ST_IDLE;
            done_nxt  = 1'b1;
          end
        end
      end
    endcase
    if (done_nxt && !err_nxt && queued_r) begin
      state_nxt = SDI_ST_RUN;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= SDI_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // one operation can wait behind the running one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      queued_r <= 1'b0;
    end else if (cmd_emg || (done_nxt && err_nxt)) begin
      queued_r <= 1'b0;
    end else if (cmd_start && state_r != SDI_ST_IDLE && !alm_on) begin
      queued_r <= 1'b1;
    end else if (done_nxt) begin
      queued_r <= 1'b0;
    end
  end

  AST_EMG_CMD: assert property (cmd_emg && state_r != SDI_ST_IDLE |=> state_r == SDI_ST_IDLE && !queued_r
                                && operation_complete) else $error("emergency command did not stop axis");
  AST_START_ALARM: assert property (state_r == SDI_ST_IDLE && cmd_start && alm_on |=> state_r == SDI_ST_IDLE)
    else $error("start taken while alarm on");
  AST_ALARM_STOP: assert property (state_r != SDI_ST_IDLE && state_r != SDI_ST_DECEL && alm_on && !emg_on && !cmd_emg
                                   && !env1_r[SDI_B_ALM_STYLE] |=> state_r == SDI_ST_IDLE && ms_err_r)
    else $error("alarm did not stop axis at once");
  AST_INPW_HOLD: assert property (state_r == SDI_ST_INPW && !inp_on && !alm_on && !emg_on && !cmd_emg
                                  |=> state_r == SDI_ST_INPW && $stable(ms_end_r) && $stable(ms_run_r))
    else $error("in-position wait ended early");
  AST_INP_ALREADY: assert property (state_r == SDI_ST_RUN && pulse_done && !homing_done && inp_on && !alm_on
                                    && !emg_on && !lim_on && !cmd_emg |=> state_r != SDI_ST_INPW)
    else $error("waited although in-position was on");

  // main status changes only at start and at completion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ms_run_r  <= 1'b0;
      ms_end_r  <= 1'b0;
      ms_err_r  <= 1'b0;
      ms_code_r <= SDI_STOP_NORMAL;
    end else if (done_nxt) begin
      ms_run_r  <= (state_nxt == SDI_ST_RUN);
      ms_end_r  <= 1'b1;
      ms_err_r  <= err_nxt;
      ms_code_r <= stop_nxt;
    end else if (state_r == SDI_ST_IDLE && state_nxt == SDI_ST_RUN) begin
      ms_run_r <= 1'b1;
      ms_end_r <= 1'b0;
      ms_err_r <= 1'b0;
    end
  end

  // sticky alarm cause, write one to clear; a new alarm stop wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_alm_r <= 1'b0;
    end else if (done_nxt && alarm_stop) begin
      cause_alm_r <= 1'b1;
    end else if (wr_en && waddr_r == SDI_ADDR_CAUSE && wstrb_r[0] && wdata_r[SDI_B_CAUSE_ALM]) begin
      cause_alm_r <= 1'b0;
    end
  end

  AST_ALARM_CAUSE: assert property (done_nxt && alarm_stop |=> cause_alm_r)
    else $error("alarm cause not set");

  // deviation clear: on width, then off delay; pulses stay gated while busy
  assign clear_on_width      = env1_r[SDI_B_EPW_LO +: 3];
  assign clear_off_delay      = env1_r[SDI_B_ETW_LO +: 2];
  assign erc_busy = erc_on_r | erc_dly_r;
  assign erc_trig = cmd_clr_out | home_trig | (fault_trig & env1_r[SDI_B_CLR_FAULT]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erc_on_r  <= 1'b0;
      erc_dly_r <= 1'b0;
      erc_cnt_r <= 12'h000;
    end else if (erc_trig) begin
      erc_on_r  <= 1'b1;
      erc_dly_r <= 1'b0;
      erc_cnt_r <= 12'h000;
    end else if (cmd_clr_rst) begin
      erc_on_r  <= 1'b0;
      erc_dly_r <= 1'b0;
      erc_cnt_r <= 12'h000;
    end else if (erc_on_r && clear_on_width != SDI_EPW_LEVEL) begin
      if (erc_cnt_r + 12'h001 == SDI_EPW_CYC[clear_on_width]) begin
        erc_on_r  <= 1'b0;
        erc_dly_r <= (SDI_ETW_CYC[clear_off_delay] != 12'h000);
        erc_cnt_r <= 12'h000;
      end else begin
        erc_cnt_r <= erc_cnt_r + 12'h001;
      end
    end else if (erc_dly_r) begin
      if (erc_cnt_r + 12'h001 >= SDI_ETW_CYC[clear_off_delay]) begin
        erc_dly_r <= 1'b0;
        erc_cnt_r <= 12'h000;
      end else begin
        erc_cnt_r <= erc_cnt_r + 12'h001;
      end
    end
  end

  AST_CLR_CMD: assert property (cmd_clr_out |=> erc_on_r ##1 deviation_clear_output == ~env1_r[SDI_B_CLR_POL] ^ 1'b1
                                || !erc_on_r) else $error("clear command did not drive output");
  AST_CLR_RST: assert property (cmd_clr_rst && !erc_trig |=> !erc_on_r && !erc_dly_r)
    else $error("clear reset did not end clear");
  AST_CLR_LEVEL: assert property (erc_on_r && clear_on_width == SDI_EPW_LEVEL && !cmd_clr_rst && $stable(clear_on_width) |=> erc_on_r)
    else $error("level clear dropped without reset");
  AST_CLR_WIDTH: assert property (erc_trig && clear_on_width == 3'h0 && !cmd_clr_rst ##1 (!erc_trig && !cmd_clr_rst
                                  && clear_on_width == 3'h0) [*8] |-> erc_on_r) else $error("clear pulse too short");

  // pins and strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      erc_pin_r  <= 1'b1;
      pulse_en_r <= 1'b0;
      decel_r    <= 1'b0;
      complete_r <= 1'b0;
    end else begin
      erc_pin_r  <= ~(erc_on_r ^ env1_r[SDI_B_CLR_POL]);
      pulse_en_r <= (state_r == SDI_ST_RUN) & ~erc_busy;
      decel_r    <= (state_r == SDI_ST_DECEL);
      complete_r <= done_nxt;
    end
  end

  AST_CLR_POL: assert property (##1 erc_pin_r == ~($past(erc_on_r) ^ $past(env1_r[SDI_B_CLR_POL])))
    else $error("clear pin polarity wrong");

  assign awready                = awready_r;
  assign wready                 = wready_r;
  assign bvalid                 = bvalid_r;
  assign bresp                  = bresp_r;
  assign arready                = arready_r;
  assign rvalid                 = rvalid_r;
  assign rdata                  = rdata_r;
  assign rresp                  = rresp_r;
  assign deviation_clear_output = erc_pin_r;
  assign pulse_enable           = pulse_en_r;
  assign decel_request          = decel_r;
  assign operation_complete     = complete_r;
endmodule

// [sdi_servo_model.sv]
`timescale 1ns/1ps
module sdi_servo_model (
  input  wire logic inpos_on,
  input  wire logic alarm_on,
  input  wire logic inpos_pol,
  input  wire logic alarm_pol,
  output logic      in_position_input,
  output logic      driver_alarm_input
);
  // pins follow the polarity the host selected, so off is never a guessed level
  assign in_position_input  = inpos_on ~^ inpos_pol;
  assign driver_alarm_input = alarm_on ~^ alarm_pol;
endmodule

// [tb_sdi_servo_if.sv]
`timescale 1ns/1ps
module tb_sdi_servo_if
  import sdi_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, pulse_done = 1'b0, homing_done = 1'b0;
  logic        emergency_stop_input = 1'b1, end_limit_input_pos = 1'b1, end_limit_input_neg = 1'b1;
  logic        high_speed_pattern = 1'b0, inpos_on = 1'b0, alarm_on = 1'b0, inpos_pol = 1'b0;
  logic        alarm_pol = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, in_position_input, driver_alarm_input;
  logic        deviation_clear_output, pulse_enable, decel_request, operation_complete;
  int          fails = 0, compares = 0, cyc = 0;

  sdi_servo_if sdi_servo_if_inst (.*);
  sdi_servo_model sdi_servo_model_inst (.*);

  always #10 aclk = ~aclk;

  // whole run needs well under 2000 cycles
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // leading edge keeps bready from being cleared and set again in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    v = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask

  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    logic [1:0]  s;
    rd(a, v, s);
    chk(n, e, v & m);
  endtask

  task automatic waitc(input int n);
    int i;
    i = 0;
    do begin
      @(posedge aclk);
      i++;
    end while (operation_complete !== 1'b1 && i < n);
    chk("complete", 32'h1, 32'(operation_complete));
  endtask

  task automatic strobe(input bit h);
    @(posedge aclk);
    if (h) homing_done <= 1'b1;
    else pulse_done <= 1'b1;
    @(posedge aclk);
    homing_done <= 1'b0;
    pulse_done <= 1'b0;
  endtask

  task automatic start();
    wr(SDI_ADDR_CMD, {24'h0, SDI_CMD_START});
  endtask

  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    rdc("env1", SDI_ADDR_ENV1, 32'hFFFF_FFFF, SDI_ENV1_RST);
    rdc("xsts", SDI_ADDR_XSTS, 32'h0001_020F, 32'h0);
    rd(8'h40, d, r);
    chk("unmapped", 32'(SDI_RESP_SLVERR), 32'(r));
    $display("test reset done");
    wr(SDI_ADDR_ENV1, 32'h0040_0000);
    inpos_pol <= 1'b1;
    wr(SDI_ADDR_MODE, 32'h0000_0200);
    start();
    strobe(1'b0);
    repeat (3) @(posedge aclk);
    rdc("wait code", SDI_ADDR_XSTS, 32'hF, {28'h0, SDI_CODE_INPW});
    rdc("held main_status", SDI_ADDR_MAIN_STATUS, 32'h3, 32'h1);
    inpos_on <= 1'b1;
    waitc(60);
    rdc("inpos state", SDI_ADDR_XSTS, 32'h1_000F, 32'h1_0000);
    start();
    strobe(1'b0);
    waitc(4);
    $display("test in-position done");
    wr(SDI_ADDR_ENV1, 32'h0040_7000);
    wr(SDI_ADDR_CMD, {24'h0, SDI_CMD_CLR_OUT});
    repeat (2) @(posedge aclk);
    chk("clear pin", 32'h0, 32'(deviation_clear_output));
    repeat (100) @(posedge aclk);
    rdc("clear level", SDI_ADDR_XSTS, 32'h200, 32'h200);
    wr(SDI_ADDR_CMD, {24'h0, SDI_CMD_CLR_RST});
    repeat (2) @(posedge aclk);
    chk("clear off", 32'h1, 32'(deviation_clear_output));
    wr(SDI_ADDR_ENV1, 32'h0040_0800);
    start();
    strobe(1'b1);
    repeat (3) @(posedge aclk);
    rdc("clear wait", SDI_ADDR_XSTS, 32'h20F, 32'h205);
    wr(SDI_ADDR_CMD, {24'h0, SDI_CMD_CLR_RST});
    repeat (4) @(posedge aclk);
    rdc("wait ended", SDI_ADDR_XSTS, 32'h20F, 32'h0);
    $display("test clear output done");
    // in-position withheld: the alarm stop must not wait for it
    wr(SDI_ADDR_ENV1, 32'h0040_0400);
    start();
    alarm_on <= 1'b1;
    inpos_on <= 1'b0;
    waitc(40);
    rdc("fault clear", SDI_ADDR_XSTS, 32'h200, 32'h200);
    rdc("alarm cause", SDI_ADDR_CAUSE, 32'h80, 32'h80);
    rdc("alarm state", SDI_ADDR_SUB_STATUS, 32'h800, 32'h800);
    start();
    rdc("refused", SDI_ADDR_XSTS, 32'hF, 32'h0);
    repeat (60) @(posedge aclk);
    rdc("width end", SDI_ADDR_XSTS, 32'h200, 32'h0);
    $display("test alarm done");
    // decelerating alarm stop: no automatic clear pulse
    alarm_on <= 1'b0;
    high_speed_pattern <= 1'b1;
    repeat (8) @(posedge aclk);
    wr(SDI_ADDR_ENV1, 32'h0040_0500);
    start();
    repeat (2) @(posedge aclk);
    chk("pulse enable", 32'h1, 32'(pulse_enable));
    alarm_on <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("decel", 32'h1, 32'(decel_request));
    strobe(1'b0);
    waitc(10);
    rdc("no decel clear", SDI_ADDR_XSTS, 32'h20F, 32'h0);
    $display("test alarm decel done");
    end_of_test();
  end
endmodule
